// file: verilog/adcf_regs.sv
// Channel power-down mask and feature-select registers behind the serial port.
// Assumes sclk, cs_n and sdi come from pins; conversion inputs are on mclk.
//
// Summary of operation
// - power-down mask sits at address 02h.
// - power-down mask resets to 00h.
// - set bit powers channel down, drops from scan.
// - mask FFh powers all down, results invalid.
// - manual mode on dead channel gives invalid result.
// - reduced variant ignores writes to absent channels.
// - reduced variant reads absent channel bits as ones.
// - feature register at 03h, resets to zero.
// - bits 7-6 hold daisy-chain position.
// - bits 5 and 3 read zero.
// - bit 4 enables threshold alarm checking.
// - bits 2-0 choose output word format.
// - format code adds tag, id, range.
// - channel tag is four-bit binary channel number.
// - empty scan mask falls back to channel 0.
`timescale 1ns/1ns
`default_nettype none
module adcf_regs
  import adcf_pkg::*;
#(
  parameter int unsigned NUM_CH = NUM_CH_FULL
) (
  input  wire logic                      mclk,
  input  wire logic                      nrst,
  input  wire logic                      sclk,
  input  wire logic                      cs_n,
  input  wire logic                      sdi,
  output logic                           sdo,
  output logic                           sdo_oe,
  input  wire logic                      manual_single_channel_mode,
  input  wire logic [2:0]                manual_channel,
  input  wire logic [7:0]                scan_include_mask,
  input  wire logic                      conv_valid,
  input  wire logic [RESULT_BITS-1:0]    conv_result,
  input  wire logic [2:0]                conv_channel,
  input  wire logic [RANGE_BITS-1:0]     conv_range,
  output logic [7:0]                     front_end_power_down_bit,
  output logic [7:0]                     scan_enable_eff,
  output logic                           scan_fallback_ch0,
  output logic                           alarm_check_en,
  output logic [ID_BITS-1:0]             chain_position_id,
  output logic [2:0]                     output_word_format_code,
  output logic [WORD_BITS-1:0]           out_word,
  output logic                           out_word_valid,
  output logic                           out_word_invalid
);

  import adcf_pkg::*;

  // Channels that exist in this variant; bits above them are absent.
  localparam logic [7:0] PRESENT_MASK = 8'(((9'h001 << NUM_CH) - 9'h001));

  // Idle pin levels held by the synchroniser in reset: sclk low, cs_n high, sdi low.
  localparam logic [2:0] PIN_IDLE = {1'b0, 1'b1, 1'b0};

  logic [2:0]           pin_sync;
  logic                 sclk_s;
  logic                 csn_s;
  logic                 sdi_s;
  logic                 sclk_prev_q;
  logic                 sclk_rise;
  logic                 sclk_fall;
  adcf_state_t          state_q;
  logic [4:0]           bit_cnt_q;
  logic [FRAME_BITS-1:0] cmd_q;
  logic [FRAME_BITS-1:0] cmd_d;
  logic [RESP_BITS-1:0] tx_q;
  logic                 resp_armed_q;
  logic [7:0]           pd_q;
  logic [7:0]           feat_q;
  logic [7:0]           rd_data;
  logic [6:0]           cmd_addr;
  logic                 cmd_write;
  logic [7:0]           cmd_data;
  logic                 frame_end;
  logic [7:0]           scan_raw;
  logic                 sel_dead;
  logic [WORD_BITS-1:0] word_c;

  // Pin inputs pass two flip-flops before anything reads them.
  adcf_sync #(
    .WIDTH   (3),
    .RST_VAL (PIN_IDLE)
  ) u_pin_sync (
    .mclk     (mclk),
    .nrst     (nrst),
    .async_in ({sclk, cs_n, sdi}),
    .sync_out (pin_sync)
  );

  assign sclk_s = pin_sync[2];
  assign csn_s  = pin_sync[1];
  assign sdi_s  = pin_sync[0];

  // Previous serial clock level for edge detection on the synchronised copy.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_q & ~csn_s;
  assign sclk_fall = ~sclk_s & sclk_prev_q & ~csn_s;

  // Incoming command bits, shifted in MSB first on rising serial edges.
  assign cmd_d     = {cmd_q[FRAME_BITS-2:0], sdi_s};
  assign cmd_addr  = cmd_d[ADDR_MSB:ADDR_LSB];
  assign cmd_write = cmd_d[WRITE_BIT];
  assign cmd_data  = cmd_d[DATA_MSB:0];
  assign frame_end = (state_q == ST_CMD) && sclk_rise && (bit_cnt_q == CMD_LAST_CNT);

  // Frame sequencer; chip select high aborts any frame in progress.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 5'h00;
    end else if (csn_s) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 5'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_q   <= ST_CMD;
          bit_cnt_q <= 5'h00;
        end
        ST_CMD: begin
          if (sclk_rise) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (frame_end) begin
              state_q <= ST_RESP;
            end
          end
        end
        ST_RESP: begin
          if (sclk_rise) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == RESP_LAST_CNT) begin
              state_q <= ST_DONE;
            end
          end
        end
        default: begin
          bit_cnt_q <= bit_cnt_q;
        end
      endcase
    end
  end

  // Command shift register.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmd_q <= '0;
    end else if (csn_s) begin
      cmd_q <= '0;
    end else if (sclk_rise && state_q == ST_CMD) begin
      cmd_q <= cmd_d;
    end
  end

  // Power-down mask; bits of absent channels never change.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pd_q <= POWER_DOWN_RST;
    end else if (frame_end && cmd_write && cmd_addr == ADDR_POWER_DOWN) begin
      pd_q <= cmd_data & PRESENT_MASK;
    end
  end

  // Feature-select register; the two reserved bits are never stored.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      feat_q <= FEATURE_RST;
    end else if (frame_end && cmd_write && cmd_addr == ADDR_FEATURE) begin
      feat_q <= cmd_data;
      feat_q[FEAT_RSVD_HI] <= 1'b0;
      feat_q[FEAT_RSVD_LO] <= 1'b0;
    end
  end

  // Read mux; absent channel bits read as ones, unmapped addresses as zero.
  always_comb begin
    if (cmd_addr == ADDR_POWER_DOWN) begin
      rd_data = pd_q | ~PRESENT_MASK;
    end else if (cmd_addr == ADDR_FEATURE) begin
      rd_data = feat_q;
    end else begin
      rd_data = UNMAPPED_READ;
    end
  end

  // Arms the read shifter once the first response clock has risen, so the
  // falling edge that closes the command phase leaves the first bit in place.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      resp_armed_q <= 1'b0;
    end else if (csn_s || frame_end) begin
      resp_armed_q <= 1'b0;
    end else if (sclk_rise && state_q == ST_RESP) begin
      resp_armed_q <= 1'b1;
    end
  end

  // Read data goes out MSB first, advancing on falling serial edges.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_q <= '0;
    end else if (csn_s) begin
      tx_q <= '0;
    end else if (frame_end) begin
      tx_q <= cmd_write ? cmd_data : rd_data;
    end else if (sclk_fall && state_q == ST_RESP && resp_armed_q) begin
      tx_q <= {tx_q[RESP_BITS-2:0], 1'b0};
    end
  end

  // Serial data pin driven from flops while the frame is selected.
  // The last bit stays on the pin after the final clock until the frame closes.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo    <= (state_q == ST_RESP || state_q == ST_DONE) ? tx_q[RESP_BITS-1] : 1'b0;
      sdo_oe <= ~csn_s;
    end
  end

  // Scan candidates: included and powered up.
  assign scan_raw = scan_include_mask & ~pd_q & PRESENT_MASK;
  assign sel_dead = pd_q[manual_channel];

  // Power-down copy and scan enables for the front end and the scanner.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      front_end_power_down_bit <= POWER_DOWN_RST;
      scan_enable_eff          <= 8'h00;
    end else begin
      front_end_power_down_bit <= pd_q;
      scan_enable_eff          <= scan_raw;
    end
  end

  // Empty scan mask flag; the scanner then converts channel 0.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scan_fallback_ch0 <= 1'b0;
    end else begin
      scan_fallback_ch0 <= (scan_include_mask & PRESENT_MASK) == 8'h00;
    end
  end

  // Feature fields for the alarm logic and the output formatter.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      alarm_check_en          <= 1'b0;
      chain_position_id       <= 2'h0;
      output_word_format_code <= 3'h0;
    end else begin
      alarm_check_en          <= feat_q[FEAT_ALARM];
      chain_position_id       <= feat_q[FEAT_ID_MSB:FEAT_ID_LSB];
      output_word_format_code <= feat_q[FEAT_FMT_MSB:FEAT_FMT_LSB];
    end
  end

  // Output word builder.
  adcf_word_fmt u_word_fmt (
    .fmt_code    (feat_q[FEAT_FMT_MSB:FEAT_FMT_LSB]),
    .result      (conv_result),
    .channel_tag ({1'b0, conv_channel}),
    .chain_id    (feat_q[FEAT_ID_MSB:FEAT_ID_LSB]),
    .range_code  (conv_range),
    .word        (word_c)
  );

  // Word strobe follows each conversion pulse by one cycle.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      out_word_valid <= 1'b0;
    end else begin
      out_word_valid <= conv_valid;
    end
  end

  // Captured word; invalid when all channels are down or the manual channel is.
  // The alarm enable is not gated, so a dead manual channel may still alarm.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      out_word         <= '0;
      out_word_invalid <= 1'b0;
    end else begin
      if (conv_valid) begin
        out_word         <= word_c;
        out_word_invalid <= ((pd_q | ~PRESENT_MASK) == ALL_POWER_DOWN)
                            || (manual_single_channel_mode && sel_dead);
      end
    end
  end

endmodule
`default_nettype wire

// file: verilog/adcf_pkg.sv
// Shared constants for the channel power-down and feature-select register block.
// Assumes a 16-bit command frame on the serial port: address, write flag, data.
package adcf_pkg;

  // Channel count of the full device and of the reduced variant.
  localparam int unsigned NUM_CH_FULL    = 8;
  localparam int unsigned NUM_CH_REDUCED = 4;

  // Command frame layout, most significant bit first on the serial line.
  localparam int unsigned FRAME_BITS     = 16;
  localparam int unsigned ADDR_MSB       = 15;
  localparam int unsigned ADDR_LSB       = 9;
  localparam int unsigned WRITE_BIT      = 8;
  localparam int unsigned DATA_MSB       = 7;
  localparam int unsigned DATA_BITS      = 8;
  localparam int unsigned RESP_BITS      = 8;
  localparam logic [4:0]  CMD_LAST_CNT   = 5'h0F;
  localparam logic [4:0]  RESP_LAST_CNT  = 5'h17;

  // Program register offsets.
  localparam logic [6:0] ADDR_POWER_DOWN = 7'h02;
  localparam logic [6:0] ADDR_FEATURE    = 7'h03;

  // Reset values, the all-down mask and the unmapped read value.
  localparam logic [7:0] POWER_DOWN_RST  = 8'h00;
  localparam logic [7:0] FEATURE_RST     = 8'h00;
  localparam logic [7:0] ALL_POWER_DOWN  = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ   = 8'h00;

  // Feature-select field positions.
  localparam int unsigned FEAT_ID_MSB    = 7;
  localparam int unsigned FEAT_ID_LSB    = 6;
  localparam int unsigned FEAT_RSVD_HI   = 5;
  localparam int unsigned FEAT_ALARM     = 4;
  localparam int unsigned FEAT_RSVD_LO   = 3;
  localparam int unsigned FEAT_FMT_MSB   = 2;
  localparam int unsigned FEAT_FMT_LSB   = 0;

  // Output word layout.
  localparam int unsigned RESULT_BITS    = 18;
  localparam int unsigned WORD_BITS      = 27;
  localparam int unsigned TAG_BITS       = 4;
  localparam int unsigned ID_BITS        = 2;
  localparam int unsigned RANGE_BITS     = 3;

  // Output word format codes.
  typedef enum logic [2:0] {
    FMT_RESULT_ONLY = 3'h0,
    FMT_WITH_TAG    = 3'h1,
    FMT_WITH_ID     = 3'h2,
    FMT_WITH_RANGE  = 3'h3
  } adcf_fmt_t;

  // Serial port frame states, Gray coded along the frame.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD  = 2'b01,
    ST_RESP = 2'b11,
    ST_DONE = 2'b10
  } adcf_state_t;

endpackage

// file: verilog/adcf_sync.sv
// Two-stage synchroniser for levels entering the mclk domain from pins.
// Assumes the inputs are asynchronous levels; only the second stage is read.
// Both stages reset to RST_VAL, the idle level of each pin, so no false level follows reset.
`timescale 1ns/1ns
`default_nettype none
module adcf_sync #(
  parameter int unsigned      WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage catches the pin, second stage is the only one read downstream.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// file: verilog/adcf_word_fmt.sv
// Combinational composer of the 27-bit serial output word.
// Assumes the caller registers the result before it reaches a pin.
`timescale 1ns/1ns
`default_nettype none
module adcf_word_fmt
  import adcf_pkg::*;
(
  input  wire logic [2:0]              fmt_code,
  input  wire logic [RESULT_BITS-1:0]  result,
  input  wire logic [TAG_BITS-1:0]     channel_tag,
  input  wire logic [ID_BITS-1:0]      chain_id,
  input  wire logic [RANGE_BITS-1:0]   range_code,
  output logic      [WORD_BITS-1:0]    word
);

  // Result goes first, then fields by format code; unused tail bits are low.
  always_comb begin
    word = '0;
    word[WORD_BITS-1 -: RESULT_BITS] = result;
    case (fmt_code)
      FMT_WITH_TAG: begin
        word[TAG_BITS+ID_BITS+RANGE_BITS-1 -: TAG_BITS] = channel_tag;
      end
      FMT_WITH_ID: begin
        word[TAG_BITS+ID_BITS+RANGE_BITS-1 -: TAG_BITS] = channel_tag;
        word[ID_BITS+RANGE_BITS-1 -: ID_BITS]           = chain_id;
      end
      FMT_WITH_RANGE: begin
        word[TAG_BITS+ID_BITS+RANGE_BITS-1 -: TAG_BITS] = channel_tag;
        word[ID_BITS+RANGE_BITS-1 -: ID_BITS]           = chain_id;
        word[RANGE_BITS-1:0]                            = range_code;
      end
      default: begin
        word[WORD_BITS-1 -: RESULT_BITS] = result;
      end
    endcase
  end

endmodule
`default_nettype wire

// file: testbench/adcf_regs_monitor.sv
// Checker for the power-down mask and feature-select register block.
// Assumes it is bound to every adcf_regs instance with NUM_CH handed on.
`timescale 1ns/1ns
`default_nettype none
module adcf_regs_monitor #(
  parameter int unsigned NUM_CH = 8
) (
  input wire logic                           mclk,
  input wire logic                           nrst,
  input wire logic                           cs_n,
  input wire logic                           sdo_oe,
  input wire logic [7:0]                     scan_include_mask,
  input wire logic                           conv_valid,
  input wire logic [adcf_pkg::RESULT_BITS-1:0] conv_result,
  input wire logic [2:0]                     conv_channel,
  input wire logic                           manual_single_channel_mode,
  input wire logic [2:0]                     manual_channel,
  input wire logic [7:0]                     front_end_power_down_bit,
  input wire logic [7:0]                     scan_enable_eff,
  input wire logic [2:0]                     output_word_format_code,
  input wire logic [adcf_pkg::WORD_BITS-1:0] out_word,
  input wire logic                           out_word_valid,
  input wire logic                           out_word_invalid
);
  import adcf_pkg::*;
  localparam logic [7:0] PRESENT = 8'((9'h001 << NUM_CH) - 9'h001);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // A conversion handed in, and a configuration left alone for three cycles.
  sequence s_conv; conv_valid; endsequence
  sequence s_cfg_steady;
    ($stable(front_end_power_down_bit) && $stable(scan_include_mask)) [*3];
  endsequence
  // Word timing and layout follow each conversion by one cycle.
  property p_word_valid; out_word_valid == $past(conv_valid); endproperty
  a_word_valid: assert property (p_word_valid) else $error("Word valid misplaced.");
  property p_result; s_conv |=> out_word[26:9] == $past(conv_result); endproperty
  a_result: assert property (p_result) else $error("Result field wrong.");
  property p_tag;
    s_conv ##0 (output_word_format_code inside {3'h1, 3'h2, 3'h3})
      |=> out_word[8:5] == {1'b0, $past(conv_channel)};
  endproperty
  a_tag: assert property (p_tag) else $error("Channel tag wrong.");
  property p_fmt0; s_conv ##0 (output_word_format_code == 3'h0) |=> out_word[8:0] == 9'h000; endproperty
  a_fmt0: assert property (p_fmt0) else $error("Low word bits not zero.");
  // Invalid flag for an all-down mask and for a dead manual channel.
  property p_all_down; s_conv ##0 (front_end_power_down_bit == 8'hFF) |=> out_word_invalid; endproperty
  a_all_down: assert property (p_all_down) else $error("All-down not invalid.");
  property p_man_down;
    s_conv ##0 (manual_single_channel_mode && front_end_power_down_bit[manual_channel])
      |=> out_word_invalid;
  endproperty
  a_man_down: assert property (p_man_down) else $error("Manual dead channel not invalid.");
  // Scan enables drop powered-down and absent channels.
  property p_scan;
    s_cfg_steady |-> scan_enable_eff == (scan_include_mask & ~front_end_power_down_bit & PRESENT);
  endproperty
  a_scan: assert property (p_scan) else $error("Scan enable wrong.");
  property p_absent; (front_end_power_down_bit & ~PRESENT) == 8'h00; endproperty
  a_absent: assert property (p_absent) else $error("Absent channel powered down.");
  // Output enable follows the select pin through the synchroniser and one flop.
  property p_oe; sdo_oe == !$past(cs_n, 3); endproperty
  a_oe: assert property (p_oe) else $error("Data output enable misplaced.");
endmodule
bind adcf_regs adcf_regs_monitor #(.NUM_CH(NUM_CH)) adcf_regs_monitor_i (
  .mclk(mclk), .nrst(nrst), .cs_n(cs_n), .sdo_oe(sdo_oe),
  .scan_include_mask(scan_include_mask),
  .conv_valid(conv_valid), .conv_result(conv_result), .conv_channel(conv_channel),
  .manual_single_channel_mode(manual_single_channel_mode), .manual_channel(manual_channel),
  .front_end_power_down_bit(front_end_power_down_bit), .scan_enable_eff(scan_enable_eff),
  .output_word_format_code(output_word_format_code), .out_word(out_word),
  .out_word_valid(out_word_valid), .out_word_invalid(out_word_invalid));
`default_nettype wire

// file: testbench/adcf_host_model.sv
// Host controller model driving 24-clock command frames on the serial port.
// Assumes mclk at 20 ns; the serial clock halves last 4 mclk, 160 ns a period.
`timescale 1ns/1ns
`default_nettype none
module adcf_host_model (
  input wire logic mclk,
  input wire logic sdo,
  output var logic sclk,
  output var logic cs_n,
  output var logic sdi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  // Between frames the data line carries a toggling pattern, never a held value.
  always @(negedge mclk) begin
    if (cs_n) sdi <= ~sdi;
  end
  // One frame: address, write flag, data, then eight response clocks sampled high.
  task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
    logic [15:0] f;
    f = {a, w, d};
    @(negedge mclk) cs_n = 1'b0;
    repeat (3) @(negedge mclk);
    for (int i = 0; i < 24; i++) begin
      sdi = (i < 16) ? f[15-i] : ~sdi;
      repeat (4) @(negedge mclk);
      sclk = 1'b1;
      repeat (4) @(negedge mclk);
      if (i >= 16) q[23-i] = sdo;
      sclk = 1'b0;
    end
    repeat (4) @(negedge mclk);
    cs_n = 1'b1;
    repeat (4) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// file: testbench/adcf_regs_tb.sv
// Testbench for the register block: full variant at index 0, reduced at 1.
// Assumes the host model, the checker bind and the design files are compiled.
`timescale 1ns/1ns
`default_nettype none
module adcf_regs_tb;
  import adcf_pkg::*;
  logic mclk, nrst, man, cv;
  logic [2:0] mch, cch, crng;
  logic [7:0] inc, q, f;
  logic [17:0] cres;
  int num_errors, n_compared;
  wire logic sclk_a [2], cs_a [2], sdi_a [2], sdo_a [2], fb_a [2], al_a [2], wv_a [2], wi_a [2];
  wire logic [7:0] pd_a [2], sen_a [2];
  wire logic [1:0] cid_a [2];
  wire logic [2:0] fmt_a [2];
  wire logic [26:0] w_a [2];
  // Both variants share the conversion inputs; each has its own host.
  for (genvar g = 0; g < 2; g++) begin : v
    adcf_regs #(.NUM_CH(g ? NUM_CH_REDUCED : NUM_CH_FULL)) adcf_regs_i (
      .mclk(mclk), .nrst(nrst), .sclk(sclk_a[g]), .cs_n(cs_a[g]), .sdi(sdi_a[g]),
      .sdo(sdo_a[g]), .sdo_oe(), .manual_single_channel_mode(man), .manual_channel(mch),
      .scan_include_mask(inc), .conv_valid(cv), .conv_result(cres), .conv_channel(cch),
      .conv_range(crng), .front_end_power_down_bit(pd_a[g]), .scan_enable_eff(sen_a[g]),
      .scan_fallback_ch0(fb_a[g]), .alarm_check_en(al_a[g]), .chain_position_id(cid_a[g]),
      .output_word_format_code(fmt_a[g]), .out_word(w_a[g]), .out_word_valid(wv_a[g]),
      .out_word_invalid(wi_a[g]));
    adcf_host_model host (.mclk(mclk), .sdo(sdo_a[g]), .sclk(sclk_a[g]), .cs_n(cs_a[g]),
      .sdi(sdi_a[g]));
  end
  // Closing task: counts, verdict, end of run.
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [26:0] e, input logic [26:0] s);
    n_compared++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask
  task automatic rw(input int k, input logic [6:0] a, input logic w, input logic [7:0] d);
    if (k == 0) v[0].host.xfer(a, w, d, q);
    else v[1].host.xfer(a, w, d, q);
  endtask
  // One conversion pulse; the word is looked at one cycle later.
  task automatic conv(input logic [2:0] ch);
    @(negedge mclk);
    cv = 1'b1;
    cch = ch;
    cres = 18'h2A5C3 ^ 18'(ch);
    crng = 3'h5;
    @(negedge mclk) cv = 1'b0;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Watchdog sized well above the thirty-five frames of the run.
  initial begin
    #600000;
    num_errors++;
    stop_test();
  end
  initial begin
    {nrst, man, cv, mch, cch, crng, cres} = '0;
    inc = 8'hFF;
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    for (int k = 0; k < 2; k++) begin
      rw(k, ADDR_POWER_DOWN, 1'b0, 8'h00); chk("pd_rst", k ? 8'hF0 : 8'h00, q);
      rw(k, ADDR_FEATURE, 1'b0, 8'h00); chk("feat_rst", 8'h00, q);
      rw(k, ADDR_POWER_DOWN, 1'b1, 8'hA5);
      rw(k, 7'h04, 1'b1, 8'h3C);
      rw(k, 7'h04, 1'b0, 8'h00); chk("unmapped", UNMAPPED_READ, q);
      rw(k, ADDR_POWER_DOWN, 1'b0, 8'h00); chk("pd_rd", k ? 8'hF5 : 8'hA5, q);
      chk("pd_out", k ? 8'h05 : 8'hA5, pd_a[k]);
      chk("scan", k ? 8'h0A : 8'h5A, sen_a[k]);
    end
    $display("Test mask done");
    inc = 8'hF0;
    repeat (6) @(negedge mclk);
    chk("fb_full", 1'b0, fb_a[0]);
    chk("fb_reduced", 1'b1, fb_a[1]);
    inc = 8'hFF;
    $display("Test fallback done");
    for (int i = 0; i < 5; i++) begin
      f = {i[1:0], 1'b0, i[0], 1'b0, i[2:0]};
      for (int k = 0; k < 2; k++) begin
        rw(k, ADDR_FEATURE, 1'b1, f);
        rw(k, ADDR_FEATURE, 1'b0, 8'h00); chk("feat_rd", f, q);
        chk("id", i[1:0], cid_a[k]);
        chk("alarm", i[0], al_a[k]);
        chk("fmt", i[2:0], fmt_a[k]);
      end
      conv(3'(i + 1));
      for (int k = 0; k < 2; k++) begin
        chk("wv", 1'b1, wv_a[k]);
        chk("wi", 1'b0, wi_a[k]);
        chk("word", {cres, (i > 0 && i < 4) ? {1'b0, cch} : 4'h0,
            (i > 1 && i < 4) ? i[1:0] : 2'h0, (i == 3) ? crng : 3'h0}, w_a[k]);
      end
    end
    $display("Test format done");
    for (int k = 0; k < 2; k++) rw(k, ADDR_POWER_DOWN, 1'b1, 8'hFF);
    conv(3'h1);
    chk("inv_all", 1'b1, wi_a[0]);
    chk("inv_all_r", 1'b1, wi_a[1]);
    rw(0, ADDR_POWER_DOWN, 1'b1, 8'h01);
    man = 1'b1;
    conv(3'h0);
    chk("inv_man", 1'b1, wi_a[0]);
    mch = 3'h1;
    conv(3'h1);
    chk("ok_man", 1'b0, wi_a[0]);
    $display("Test invalid done");
    stop_test();
  end
endmodule
`default_nettype wire
